// ===== design/pic_controller.sv
// prioritized interrupt controller: enables, latches, selector and acceptance sequencer
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_controller (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // special-function register access
  input wire pic_pkg::pic_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // interrupt sources, one-cycle request pulses, index 2..15
  input wire logic [15:0] irq_in,
  input wire logic timer_counter_four_irq,
  input wire logic external_input_three_irq,
  // cpu core handshake
  input wire logic instr_done,
  input wire logic enable_instr,
  input wire logic disable_instr,
  input wire logic maskable_return_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic [7:0] stacked_status,
  input wire logic [7:0] processor_status_word,
  input wire logic [15:0] pc_current,
  input wire logic [15:0] sp_current,
  // sequencing outputs
  output logic int_pending,
  output logic accept_busy,
  output pic_pkg::pic_cpu_cmd_t cpu_cmd,
  output logic [15:0] sp_next,
  output logic master_enable_flag
);
  // ************************************
  // registers
  // ************************************
  logic [15:4] source_enable_flag;
  logic [7:0] shared_source_selector;
  logic [15:0] request_latch;
  logic [15:0] set_vec;
  logic [15:0] sw_clr;
  logic [15:0] ack_clr;
  logic [15:0] eligible;
  logic [3:0] win_idx;
  logic win_any;
  logic [3:0] acc_idx, next_acc_idx;
  logic saved_mef, next_saved_mef;
  logic next_mef;
  logic [15:4] next_sef;
  logic [7:0] next_sel;
  logic [7:0] next_rdata;
  logic [5:0] step_cnt, next_step_cnt;
  pic_pkg::pic_state_t state, next_state;
  pic_pkg::pic_cpu_cmd_t next_cmd;
  logic [15:0] next_sp;
  logic next_busy;
  logic next_pending;
  logic wr_el, wr_eh, wr_ll, wr_lh, wr_sel;

  assign wr_el = sfr_req.wr && sfr_req.addr == `PIC_ADDR_ENABLE_LOW;
  assign wr_eh = sfr_req.wr && sfr_req.addr == `PIC_ADDR_ENABLE_HIGH;
  assign wr_ll = sfr_req.wr && sfr_req.addr == `PIC_ADDR_LATCH_LOW;
  assign wr_lh = sfr_req.wr && sfr_req.addr == `PIC_ADDR_LATCH_HIGH;
  assign wr_sel = sfr_req.wr && sfr_req.addr == `PIC_ADDR_SELECTOR;

  // ************************************
  // request latches
  // ************************************
  always_comb begin
    set_vec = irq_in;
    set_vec[1:0] = 2'b00;
    set_vec[`PIC_SHARED_SOURCE] = shared_source_selector[`PIC_SELECTOR_SHARED_BIT] ?
      external_input_three_irq : timer_counter_four_irq;
    sw_clr = 16'h0000;
    if (wr_ll) begin
      sw_clr[7:0] = ~sfr_req.wdata;
    end
    if (wr_lh) begin
      sw_clr[15:8] = ~sfr_req.wdata;
    end
    sw_clr[1:0] = 2'b00;
    ack_clr = 16'h0000;
    if (state == pic_pkg::PIC_WAIT && step_cnt == 6'd0) begin
      ack_clr[acc_idx] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 2; gi < 16; gi++) begin : g_latch
      pic_latch_bit u_bit (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .set_req(set_vec[gi]),
        .sw_clear(sw_clr[gi]),
        .ack_clear(ack_clr[gi]),
        .latched(request_latch[gi])
      );
    end
  endgenerate
  assign request_latch[1:0] = 2'b00;

  // ************************************
  // priority selection
  // ************************************
  always_comb begin
    eligible = 16'h0000;
    eligible[3:2] = request_latch[3:2];
    for (int i = 4; i < 16; i++) begin
      eligible[i] = request_latch[i] && source_enable_flag[i] && master_enable_flag;
    end
    win_any = |eligible;
    win_idx = 4'd0;
    for (int i = 15; i >= 2; i--) begin
      if (eligible[i]) begin
        win_idx = 4'(i);
      end
    end
  end

  // ************************************
  // enable registers and selector
  // ************************************
  always_comb begin
    next_mef = master_enable_flag;
    next_sef = source_enable_flag;
    next_sel = shared_source_selector;
    if (wr_el) begin
      next_mef = sfr_req.wdata[`PIC_MASTER_ENABLE_BIT];
      next_sef[7:4] = sfr_req.wdata[7:4];
    end
    if (wr_eh) begin
      next_sef[15:8] = sfr_req.wdata;
    end
    if (wr_sel) begin
      next_sel = sfr_req.wdata;
    end
    if (enable_instr) begin
      next_mef = 1'b1;
    end
    if (disable_instr) begin
      next_mef = 1'b0;
    end
    if (maskable_return_instr || nonmaskable_return_instr) begin
      next_mef = stacked_status[`PIC_MASTER_ENABLE_BIT];
    end
    if (state == pic_pkg::PIC_IDLE && instr_done && win_any) begin
      next_mef = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `PIC_ADDR_ENABLE_LOW: next_rdata = {source_enable_flag[7:4], 3'b000, master_enable_flag};
        `PIC_ADDR_ENABLE_HIGH: next_rdata = source_enable_flag[15:8];
        `PIC_ADDR_LATCH_LOW: next_rdata = request_latch[7:0];
        `PIC_ADDR_LATCH_HIGH: next_rdata = request_latch[15:8];
        `PIC_ADDR_SELECTOR: next_rdata = shared_source_selector;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      master_enable_flag <= 1'b0;
      source_enable_flag <= 12'h000;
      shared_source_selector <= `PIC_SELECTOR_RESET;
      sfr_rdata <= 8'h00;
    end else begin
      master_enable_flag <= next_mef;
      source_enable_flag <= next_sef;
      shared_source_selector <= next_sel;
      sfr_rdata <= next_rdata;
    end
  end

  // ************************************
  // acceptance sequencer
  // ************************************
  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_acc_idx = acc_idx;
    next_saved_mef = saved_mef;
    next_cmd = '0;
    next_sp = sp_next;
    next_busy = accept_busy;
    next_pending = win_any;
    case (state)
      pic_pkg::PIC_IDLE: begin
        if (instr_done && win_any) begin
          next_saved_mef = master_enable_flag;
          next_acc_idx = win_idx;
          next_step_cnt = 6'd0;
          next_busy = 1'b1;
          next_state = pic_pkg::PIC_WAIT;
        end
      end
      pic_pkg::PIC_WAIT: begin
        next_state = pic_pkg::PIC_PUSH_PSW;
      end
      pic_pkg::PIC_PUSH_PSW: begin
        next_cmd.push = 1'b1;
        next_cmd.push_data = {processor_status_word[7:1], saved_mef};
        next_state = pic_pkg::PIC_PUSH_PCH;
      end
      pic_pkg::PIC_PUSH_PCH: begin
        next_cmd.push = 1'b1;
        next_cmd.push_data = pc_current[15:8];
        next_state = pic_pkg::PIC_PUSH_PCL;
      end
      pic_pkg::PIC_PUSH_PCL: begin
        next_cmd.push = 1'b1;
        next_cmd.push_data = pc_current[7:0];
        next_sp = sp_current - 16'(`PIC_STACK_DROP);
        next_state = pic_pkg::PIC_VECTOR;
      end
      pic_pkg::PIC_VECTOR: begin
        next_cmd.load_pc = 1'b1;
        next_cmd.vector = (acc_idx < 4'd4) ? `PIC_VECTOR_TOP - 16'({acc_idx, 1'b0}) + 16'h0004 :
          16'hFFFE - 16'({acc_idx, 1'b0});
        next_state = pic_pkg::PIC_FINISH;
      end
      pic_pkg::PIC_FINISH: begin
        if (step_cnt == 6'(`PIC_ACCEPT_CLOCKS - 1)) begin
          next_busy = 1'b0;
          next_state = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        next_state = pic_pkg::PIC_IDLE;
        next_busy = 1'b0;
      end
    endcase
    if (state != pic_pkg::PIC_IDLE) begin
      next_step_cnt = step_cnt + 6'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= pic_pkg::PIC_IDLE;
      step_cnt <= 6'd0;
      acc_idx <= 4'd0;
      saved_mef <= 1'b0;
      cpu_cmd <= '0;
      sp_next <= 16'h0000;
      accept_busy <= 1'b0;
      int_pending <= 1'b0;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      acc_idx <= next_acc_idx;
      saved_mef <= next_saved_mef;
      cpu_cmd <= next_cmd;
      sp_next <= next_sp;
      accept_busy <= next_busy;
      int_pending <= next_pending;
    end
  end

  // ************************************
  // assertions
  // ************************************
  a_master_gates: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state == pic_pkg::PIC_IDLE && !master_enable_flag && request_latch[3:2] == 2'b00) |=> !accept_busy)
    else $error("maskable accepted with master off");
  a_accept_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state == pic_pkg::PIC_IDLE && instr_done && win_any) |=> !master_enable_flag)
    else $error("master enable not cleared at accept");
  a_return_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
    (maskable_return_instr && state == pic_pkg::PIC_IDLE && !(instr_done && win_any))
    |=> master_enable_flag == $past(stacked_status[0])) else $error("return did not reload");
  a_ack_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ack_clr != 16'h0000 && set_vec == 16'h0000) |=> ((request_latch & $past(ack_clr)) == 16'h0000))
    else $error("accepted latch not cleared");
  a_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_ll && set_vec[5] && !sfr_req.wdata[5]) |=> request_latch[5]) else $error("request lost on clear");
  a_shared_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!shared_source_selector[6] && !timer_counter_four_irq && !request_latch[11] && !ack_clr[11])
    |=> !request_latch[11]) else $error("unselected source set shared latch");
  a_push_order: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state == pic_pkg::PIC_WAIT) |=> ##1 cpu_cmd.push ##1 cpu_cmd.push ##1 cpu_cmd.push ##1 cpu_cmd.load_pc)
    else $error("push sequence broken");
  a_accept_len: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(accept_busy) |-> accept_busy [*8]) else $error("acceptance too short");
  a_enable_reset: assert property (@(posedge sys_clk)
    $rose(rstn) |-> source_enable_flag == 12'h000) else $error("enable flags not reset");
  c_accept: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(accept_busy));
  c_nonmask: cover property (@(posedge sys_clk) disable iff (!rstn) accept_busy && acc_idx == 4'd3);
  c_return: cover property (@(posedge sys_clk) disable iff (!rstn) maskable_return_instr);
endmodule : pic_controller

// ===== design/pic_map.svh
// register map, field positions, reset values and timing counts of the interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_ADDR_ENABLE_LOW 16'h003A
`define PIC_ADDR_ENABLE_HIGH 16'h003B
`define PIC_ADDR_LATCH_LOW 16'h003C
`define PIC_ADDR_LATCH_HIGH 16'h003D
`define PIC_ADDR_SELECTOR 16'h0038
`define PIC_MASTER_ENABLE_BIT 0
`define PIC_SELECTOR_SHARED_BIT 6
`define PIC_ENABLE_RESET 16'h0000
`define PIC_LATCH_RESET 16'h0000
`define PIC_SELECTOR_RESET 8'h00
`define PIC_SHARED_SOURCE 11
`define PIC_FIRST_MASKABLE 4
`define PIC_ACCEPT_MCYCLES 8
`define PIC_CLOCKS_PER_MCYCLE 4
`define PIC_ACCEPT_CLOCKS (`PIC_ACCEPT_MCYCLES * `PIC_CLOCKS_PER_MCYCLE)
`define PIC_WORST_LATENCY_CLOCKS 38
`define PIC_STACK_DROP 3
`define PIC_VECTOR_TOP 16'hFFFA
`endif

// ===== design/pic_pkg.sv
// types of the prioritized interrupt controller
package pic_pkg;
  // ************************************
  // register bus access from the cpu core
  // ************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pic_sfr_req_t;

  // ************************************
  // cpu sequencing commands per step
  // ************************************
  typedef struct packed {
    logic push;
    logic [7:0] push_data;
    logic load_pc;
    logic [15:0] vector;
  } pic_cpu_cmd_t;

  typedef enum logic [2:0] {
    PIC_IDLE = 3'b000,
    PIC_WAIT = 3'b001,
    PIC_PUSH_PSW = 3'b010,
    PIC_PUSH_PCH = 3'b011,
    PIC_PUSH_PCL = 3'b100,
    PIC_VECTOR = 3'b101,
    PIC_FINISH = 3'b110
  } pic_state_t;
endpackage : pic_pkg

// ===== design/pic_latch_bit.sv
// one request latch bit with set over clear priority
`timescale 1ns/1ps
module pic_latch_bit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic set_req,
  input wire logic sw_clear,
  input wire logic ack_clear,
  // state
  output logic latched
);
  logic next_latched;

  always_comb begin
    next_latched = latched;
    if (sw_clear || ack_clear) begin
      next_latched = 1'b0;
    end
    if (set_req) begin
      next_latched = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latched <= 1'b0;
    end else begin
      latched <= next_latched;
    end
  end
endmodule : pic_latch_bit

// ===== sim/pic_cpu_model.sv
// cpu core model: instruction ends, cpu state and capture of stack traffic
`timescale 1ns/1ps
module pic_cpu_model #(parameter int INSTR_CLKS = 8) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // sequencing from the controller
  input wire pic_pkg::pic_cpu_cmd_t cpu_cmd,
  // cpu state
  output logic instr_done,
  output logic [7:0] processor_status_word,
  output logic [15:0] pc_current,
  output logic [15:0] sp_current,
  output logic [7:0] stacked_status,
  // captured stack traffic
  output logic [23:0] pushed,
  output logic [15:0] vector_seen
);
  int cnt;
  assign processor_status_word = 8'hA4;
  assign pc_current = 16'h1234;
  assign sp_current = 16'h0200;
  // a return pops the status byte that acceptance pushed first
  assign stacked_status = pushed[23:16];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      instr_done <= 1'b0;
      pushed <= '0;
      vector_seen <= '0;
    end else begin
      cnt <= (cnt == INSTR_CLKS - 1) ? 0 : cnt + 1;
      instr_done <= (cnt == INSTR_CLKS - 1);
      if (cpu_cmd.push) begin
        pushed <= {pushed[15:0], cpu_cmd.push_data};
      end
      if (cpu_cmd.load_pc) begin
        vector_seen <= cpu_cmd.vector;
      end
    end
  end
endmodule : pic_cpu_model

// ===== sim/tb_top.sv
// self-checking bench of the interrupt controller with a cpu core model
`timescale 1ns/1ps
`include "pic_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  logic sys_clk, rstn, instr_done, int_pending, accept_busy, master_enable_flag;
  pic_pkg::pic_sfr_req_t sfr_req;
  pic_pkg::pic_cpu_cmd_t cpu_cmd;
  logic [7:0] sfr_rdata, stacked_status, processor_status_word;
  logic [15:0] irq_in, pc_current, sp_current, sp_next, vector_seen;
  logic [23:0] pushed;
  logic [1:0] shr;
  logic [3:0] ins;
  int err_count = 0;
  int tests_run = 0;

  pic_controller dut_u (.sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_in(irq_in), .timer_counter_four_irq(shr[0]), .external_input_three_irq(shr[1]),
    .instr_done(instr_done), .enable_instr(ins[0]), .disable_instr(ins[1]), .maskable_return_instr(ins[2]),
    .nonmaskable_return_instr(ins[3]), .stacked_status(stacked_status),
    .processor_status_word(processor_status_word), .pc_current(pc_current), .sp_current(sp_current),
    .int_pending(int_pending), .accept_busy(accept_busy), .cpu_cmd(cpu_cmd), .sp_next(sp_next),
    .master_enable_flag(master_enable_flag));
  pic_cpu_model cpu_u (.sys_clk(sys_clk), .rstn(rstn), .cpu_cmd(cpu_cmd), .instr_done(instr_done),
    .processor_status_word(processor_status_word), .pc_current(pc_current), .sp_current(sp_current),
    .stacked_status(stacked_status), .pushed(pushed), .vector_seen(vector_seen));

  // ************************************
  // access tasks
  // ************************************
  task automatic drive(input logic [15:0] irq, input logic [1:0] s, input logic [3:0] i);
    @(posedge sys_clk);
    #2;
    irq_in = irq;
    shr = s;
    ins = i;
    @(posedge sys_clk);
    #2;
    irq_in = '0;
    shr = '0;
    ins = '0;
  endtask : drive
  task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d, input logic [15:0] irq);
    @(posedge sys_clk);
    #2;
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    irq_in = irq;
    @(posedge sys_clk);
    #2;
    sfr_req = '0;
    irq_in = '0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #2;
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    #2;
    sfr_req = '0;
    `CHK(sfr_rdata, e)
  endtask : sfr_rd
  task automatic idle_check();
    repeat (`PIC_WORST_LATENCY_CLOCKS) @(posedge sys_clk);
    #2;
    `CHK(accept_busy, 1'b0)
    `CHK(int_pending, 1'b0)
  endtask : idle_check
  // waits for acceptance, then checks its length, stack traffic and vector
  task automatic accept(input logic [15:0] vec, input logic me);
    int n = 0;
    int b = 0;
    while (accept_busy !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    `CHK(n <= `PIC_WORST_LATENCY_CLOCKS, 1'b1)
    `CHK(master_enable_flag, 1'b0)
    `CHK(int_pending, 1'b1)
    while (accept_busy === 1'b1 && b < 60) begin
      @(posedge sys_clk);
      #2;
      b++;
    end
    `CHK(b, `PIC_ACCEPT_CLOCKS)
    `CHK(pushed, {processor_status_word[7:1], me, pc_current})
    `CHK(vector_seen, vec)
    `CHK(sp_next, sp_current - 16'h0003)
  endtask : accept
  task automatic tally_and_finish();
    $display("counts: checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************
  // clock, watchdog and tests
  // ************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #(25 * 6000);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    sfr_req = '0;
    irq_in = '0;
    shr = '0;
    ins = '0;
    rstn = 1'b0;
    repeat (10) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    sfr_rd(`PIC_ADDR_ENABLE_LOW, 8'h00);
    sfr_rd(`PIC_ADDR_ENABLE_HIGH, 8'h00);
    sfr_rd(`PIC_ADDR_LATCH_LOW, 8'h00);
    sfr_rd(`PIC_ADDR_LATCH_HIGH, 8'h00);
    $display("test reset_values done");
    sfr_wr(`PIC_ADDR_ENABLE_LOW, 8'h20, 16'h0000);
    drive(16'h0020, 2'b00, 4'h0);
    idle_check();
    sfr_rd(`PIC_ADDR_LATCH_LOW, 8'h20);
    sfr_wr(`PIC_ADDR_LATCH_LOW, 8'hDF, 16'h0020);
    sfr_rd(`PIC_ADDR_LATCH_LOW, 8'h20);
    sfr_wr(`PIC_ADDR_LATCH_LOW, 8'hDF, 16'h0000);
    sfr_rd(`PIC_ADDR_LATCH_LOW, 8'h00);
    $display("test latch_and_master_off done");
    drive(16'h0000, 2'b00, 4'b0001);
    sfr_rd(`PIC_ADDR_ENABLE_LOW, 8'h21);
    drive(16'h0020, 2'b00, 4'h0);
    accept(16'hFFF4, 1'b1);
    sfr_rd(`PIC_ADDR_LATCH_LOW, 8'h00);
    drive(16'h0000, 2'b00, 4'b0100);
    `CHK(master_enable_flag, 1'b1)
    $display("test acceptance done");
    drive(16'h0000, 2'b00, 4'b0010);
    sfr_wr(`PIC_ADDR_ENABLE_LOW, 8'h40, 16'h0000);
    sfr_wr(`PIC_ADDR_ENABLE_HIGH, 8'h02, 16'h0000);
    drive(16'h0260, 2'b00, 4'h0);
    idle_check();
    drive(16'h0000, 2'b00, 4'b0001);
    accept(16'hFFF2, 1'b1);
    idle_check();
    sfr_wr(`PIC_ADDR_ENABLE_LOW, 8'h00, 16'h0000);
    drive(16'h0000, 2'b00, 4'b0001);
    accept(16'hFFEC, 1'b1);
    drive(16'h0000, 2'b00, 4'b0100);
    drive(16'h0000, 2'b00, 4'b0100);
    idle_check();
    $display("test priority done");
    drive(16'h0000, 2'b00, 4'b0010);
    sfr_wr(`PIC_ADDR_LATCH_LOW, 8'hDF, 16'h0000);
    drive(16'h0008, 2'b00, 4'h0);
    accept(16'hFFF8, 1'b0);
    drive(16'h0000, 2'b00, 4'b1000);
    `CHK(master_enable_flag, 1'b0)
    $display("test nonmaskable done");
    for (int s = 0; s < 2; s++) begin
      sfr_wr(`PIC_ADDR_SELECTOR, (s == 1) ? 8'h40 : 8'h00, 16'h0000);
      drive(16'h0000, (s == 1) ? 2'b01 : 2'b10, 4'h0);
      sfr_rd(`PIC_ADDR_LATCH_HIGH, 8'h00);
      drive(16'h0000, (s == 1) ? 2'b10 : 2'b01, 4'h0);
      sfr_rd(`PIC_ADDR_LATCH_HIGH, 8'h08);
      sfr_wr(`PIC_ADDR_LATCH_HIGH, 8'hF7, 16'h0000);
      sfr_rd(`PIC_ADDR_LATCH_HIGH, 8'h00);
    end
    $display("test shared_selector done");
    tally_and_finish();
  end
endmodule : tb_top
